/* hdl/pbr_pkg.sv */
package pbr_pkg;
  // widths of the primary bus
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  // cpu_clock_phase_one is derived from clk_sys by this divider (half period in clk_sys cycles)
  localparam logic [1:0] PHASE_HALF = 2'h2;
  // least low time of the request, in phase periods
  localparam int REQ_MIN_PHASES = 2;
  // reset values
  localparam logic ACK_RST = 1'b1;
  localparam logic BUS_STROBE_N_RST = 1'b1;
  // release sequence states
  typedef enum logic [2:0] {
    PBR_OWN,
    PBR_DRAIN,
    PBR_PARK,
    PBR_FLOAT,
    PBR_LINGER
  } pbr_state_e;
endpackage

/* hdl/pbr_release.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - request is asynchronous; may add a cycle
// - inhibit ends release and blocks new ones
// - during request, core bus access stalls
// - one write may post; second write stalls
// - acknowledge changes only at phase-one fall
// - strobe goes high, then floats, restored after
// - direction, address, data float during release
// - acknowledge holds one phase after request rises
module pbr_release
  import pbr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic bus_request_n,
  input wire logic bus_release_inhibit,
  input wire logic coreReq,
  input wire logic coreWrite,
  input wire logic [ADDR_W-1:0] coreAddr,
  input wire logic [DATA_W-1:0] coreWdata,
  input wire logic [DATA_W-1:0] busDataIn,
  output logic coreStall,
  output logic [DATA_W-1:0] coreRdata,
  output logic cpu_clock_phase_one,
  output logic bus_grant_ack_n,
  output logic bus_strobe_n,
  output logic busStrobeOe,
  output logic readWriteDir,
  output logic readWriteOe,
  output logic [ADDR_W-1:0] busAddr,
  output logic busAddrOe,
  output logic [DATA_W-1:0] busDataOut,
  output logic busDataOe
);
  logic reqSyncN; // synchronised request, active low
  logic [1:0] phaseCnt_reg; // phase divider count
  logic [1:0] phaseCnt_next;
  logic phase_next;
  logic phaseFall; // phase one falls on this edge
  pbr_state_e state_reg;
  pbr_state_e state_next;
  logic ack_next;
  logic bus_strobe_n_next;
  logic strbOe_next;
  logic rwOe_next;
  logic addrOe_next;
  logic dataOe_next;
  logic rw_next;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_next;
  logic [DATA_W-1:0] rdata_next;
  logic cycleActive_reg; // one bus access spans one phase period
  logic cycleActive_next;
  logic postValid_reg; // one write held while released
  logic postValid_next;
  logic [ADDR_W-1:0] postAddr_reg;
  logic [ADDR_W-1:0] postAddr_next;
  logic [DATA_W-1:0] postData_reg;
  logic [DATA_W-1:0] postData_next;
  logic stall_next;
  logic released; // bus is parked for release or granted away
  logic wantRelease;
  default clocking cbSys @(posedge clk_sys); endclocking // checks below all run on clk_sys
  default disable iff (!rstn); // and sleep through reset

  // pin crosses into clk_sys through two flops
  pbr_sync uReqSync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .asyncIn(bus_request_n),
    .syncOut(reqSyncN)
  );

  // phase-one clock divider; every pin update below waits for its fall
  always_comb
  begin
    phaseCnt_next = phaseCnt_reg + 2'h1;
    phase_next = cpu_clock_phase_one;
    if (phaseCnt_reg == PHASE_HALF - 2'h1)
    begin
      phaseCnt_next = 2'h0;
      phase_next = ~cpu_clock_phase_one;
    end
  end
  assign phaseFall = (phaseCnt_reg == PHASE_HALF - 2'h1) && cpu_clock_phase_one;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      phaseCnt_reg <= 2'h0;
      cpu_clock_phase_one <= 1'b0;
    end
    else
    begin
      phaseCnt_reg <= phaseCnt_next;
      cpu_clock_phase_one <= phase_next;
    end
  end

  // inhibit overrides any request
  assign wantRelease = !reqSyncN && !bus_release_inhibit;
  assign released = (state_reg == PBR_PARK) || (state_reg == PBR_FLOAT) || (state_reg == PBR_LINGER);

  // release sequencer and bus access engine
  always_comb
  begin
    state_next = state_reg;
    ack_next = bus_grant_ack_n;
    bus_strobe_n_next = bus_strobe_n;
    strbOe_next = busStrobeOe;
    rwOe_next = readWriteOe;
    addrOe_next = busAddrOe;
    dataOe_next = busDataOe;
    rw_next = readWriteDir;
    addr_next = busAddr;
    wdata_next = busDataOut;
    rdata_next = coreRdata;
    cycleActive_next = cycleActive_reg;
    postValid_next = postValid_reg;
    postAddr_next = postAddr_reg;
    postData_next = postData_reg;
    stall_next = 1'b0;
    if (phaseFall)
    begin
      case (state_reg)
        PBR_OWN:
        begin
          // finish the access first, grant never cuts it short
          if (cycleActive_reg)
          begin
            cycleActive_next = 1'b0;
            bus_strobe_n_next = 1'b1;
            dataOe_next = 1'b0;
            if (readWriteDir)
            begin
              rdata_next = busDataIn;
            end
          end
          else if (wantRelease)
          begin
            state_next = PBR_PARK;
          end
          else if (postValid_reg)
          begin
            // drain the posted write once the bus is back
            postValid_next = 1'b0;
            cycleActive_next = 1'b1;
            bus_strobe_n_next = 1'b0;
            rw_next = 1'b0;
            addr_next = postAddr_reg;
            wdata_next = postData_reg;
            dataOe_next = 1'b1;
          end
          else if (coreReq)
          begin
            cycleActive_next = 1'b1;
            bus_strobe_n_next = 1'b0;
            rw_next = !coreWrite;
            addr_next = coreAddr;
            wdata_next = coreWdata;
            dataOe_next = coreWrite;
          end
        end
        PBR_PARK:
        begin
          // strobe already parked high; now float everything and grant
          strbOe_next = 1'b0;
          rwOe_next = 1'b0;
          addrOe_next = 1'b0;
          dataOe_next = 1'b0;
          ack_next = 1'b0;
          state_next = PBR_FLOAT;
        end
        PBR_FLOAT:
        begin
          if (bus_release_inhibit)
          begin
            state_next = PBR_OWN;
            ack_next = 1'b1;
            strbOe_next = 1'b1;
            rwOe_next = 1'b1;
            addrOe_next = 1'b1;
          end
          else if (reqSyncN)
          begin
            state_next = PBR_LINGER;
          end
        end
        PBR_LINGER:
        begin
          // one extra phase with acknowledge still low
          state_next = PBR_OWN;
          ack_next = 1'b1;
          strbOe_next = 1'b1;
          rwOe_next = 1'b1;
          addrOe_next = 1'b1;
        end
        default:
        begin
          state_next = PBR_OWN;
        end
      endcase
    end
    // accept one write while released, stall anything else
    if (released && coreReq)
    begin
      if (coreWrite && !postValid_reg && !coreStall)
      begin
        postValid_next = 1'b1;
        postAddr_next = coreAddr;
        postData_next = coreWdata;
      end
      else
      begin
        stall_next = 1'b1;
      end
    end
    else if (coreReq && !(cycleActive_next && !cycleActive_reg && !postValid_reg)) // held until launched
    begin
      stall_next = 1'b1;
    end
  end

  // register everything; pins come straight from flops
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg <= PBR_OWN;
      bus_grant_ack_n <= ACK_RST;
      bus_strobe_n <= BUS_STROBE_N_RST;
      busStrobeOe <= 1'b1;
      readWriteOe <= 1'b1;
      busAddrOe <= 1'b1;
      busDataOe <= 1'b0;
      readWriteDir <= 1'b1;
      busAddr <= '0;
      busDataOut <= '0;
      coreRdata <= '0;
      cycleActive_reg <= 1'b0;
      postValid_reg <= 1'b0;
      postAddr_reg <= '0;
      postData_reg <= '0;
      coreStall <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bus_grant_ack_n <= ack_next;
      bus_strobe_n <= bus_strobe_n_next;
      busStrobeOe <= strbOe_next;
      readWriteOe <= rwOe_next;
      busAddrOe <= addrOe_next;
      busDataOe <= dataOe_next;
      readWriteDir <= rw_next;
      busAddr <= addr_next;
      busDataOut <= wdata_next;
      coreRdata <= rdata_next;
      cycleActive_reg <= cycleActive_next;
      postValid_reg <= postValid_next;
      postAddr_reg <= postAddr_next;
      postData_reg <= postData_next;
      coreStall <= stall_next;
    end
  end

  // acknowledge only moves at a phase-one fall
  a_ack_on_fall: assert property ($changed(bus_grant_ack_n) |-> $past(phaseFall))
    else $error("acknowledge moved off the phase-one fall");
  // strobe is high whenever it floats
  a_strobe_parked: assert property (!busStrobeOe |-> bus_strobe_n)
    else $error("strobe floated while low");
  // granted means direction, address and data all float
  a_grant_floats: assert property (!bus_grant_ack_n |-> !readWriteOe && !busAddrOe && !busDataOe)
    else $error("bus driven during grant");
  // inhibit reclaims within two phase periods
  a_inhibit_reclaim: assert property ((bus_release_inhibit && !bus_grant_ack_n)[*8] |-> bus_grant_ack_n)
    else $error("inhibit did not reclaim the bus");
  // no grant while an access runs
  a_no_grant_mid: assert property ($fell(bus_grant_ack_n) |-> !cycleActive_reg)
    else $error("grant during an access");
  // strobe never active while released
  a_no_strobe_rel: assert property (released |-> bus_strobe_n)
    else $error("strobe active while released");
  // a second write while one is posted stalls
  a_second_stall: assert property (released && coreReq && coreWrite && postValid_reg |=> coreStall)
    else $error("second write did not stall");
  // ack stays low at least one phase after request rises
  a_ack_linger: assert property ((state_reg == PBR_LINGER) |-> !bus_grant_ack_n)
    else $error("acknowledge released early");
  // synchronised request lags the pin by two edges
  a_req_sync: assert property ($past(bus_request_n, 2) == reqSyncN || !$past(rstn, 2))
    else $error("request synchroniser depth wrong");
  // release steps: the parking fall floats strobe and direction and grants in the same edge
  sequence s_parkFall; phaseFall && (state_reg == PBR_PARK); endsequence
  sequence s_floatGrant; !bus_grant_ack_n && !busStrobeOe && !readWriteOe; endsequence
  a_park_grant: assert property (s_parkFall |=> s_floatGrant)
    else $error("parking fall did not float and grant");
endmodule

/* hdl/pbr_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for an asynchronous level
module pbr_sync
  import pbr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_reg; // metastable stage, read only by stage two
  logic stage1_next;
  logic syncOut_next;

  // next values: shift the level along
  always_comb
  begin
    stage1_next = asyncIn;
    syncOut_next = stage1_reg;
  end

  // inactive level is high, so reset to high
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      stage1_reg <= 1'b1;
      syncOut <= 1'b1;
    end
    else
    begin
      stage1_reg <= stage1_next;
      syncOut <= syncOut_next;
    end
  end
endmodule

/* verif/pbr_bus_master.sv */
`timescale 1ns/100ps
// outside master plus the memory that answers reads on the primary bus
module pbr_bus_master
  import pbr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic wantBus,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic busAddrOe,
  input wire logic readWriteDir,
  input wire logic bus_strobe_n,
  output logic bus_request_n,
  output logic [DATA_W-1:0] busDataIn
);
  int lowCnt = 0; // cycles the request has been low
  logic [DATA_W-1:0] lastData = '0; // last value on the data pins
  initial bus_request_n = 1'b1;
  // request level; never lifted before two phase periods, even if wantBus drops early
  always @(posedge clk_sys)
  begin
    lowCnt <= bus_request_n ? 0 : lowCnt + 1;
    if (wantBus)
      bus_request_n <= 1'b0;
    else if (lowCnt >= REQ_MIN_PHASES * 2 * int'(PHASE_HALF))
      bus_request_n <= 1'b1;
  end
  // read data only while a read strobe is out; otherwise a changing pattern, not a stale value
  always @(posedge clk_sys)
    lastData <= busDataIn;
  assign busDataIn = (readWriteDir && busAddrOe && !bus_strobe_n) ? {8'hA5, busAddr} : ~lastData;
endmodule

/* verif/tb_pbr_release.sv */
`timescale 1ns/100ps
module tb_pbr_release;
  import pbr_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wantBus = 1'b0; // tells the master model to ask for the bus
  logic inhibit = 1'b0;
  logic coreReq = 1'b0;
  logic coreWrite = 1'b0;
  logic [ADDR_W-1:0] coreAddr = '0;
  logic [DATA_W-1:0] coreWdata = '0;
  logic reqN, stall, phase, ackN, strbN, strbOe, rw, rwOe, addrOe, dataOe;
  logic [DATA_W-1:0] dataIn, rdata, dataOut;
  logic [ADDR_W-1:0] addr;
  int failures = 0;
  int check_count = 0;
  int cycleCount = 0; // ceiling far above the few hundred cycles the tests need
  always #2 clk_sys = ~clk_sys;
  pbr_release u_pbr_release (.clk_sys(clk_sys), .rstn(rstn), .bus_request_n(reqN),
    .bus_release_inhibit(inhibit), .coreReq(coreReq), .coreWrite(coreWrite), .coreAddr(coreAddr),
    .coreWdata(coreWdata), .busDataIn(dataIn), .coreStall(stall), .coreRdata(rdata),
    .cpu_clock_phase_one(phase), .bus_grant_ack_n(ackN), .bus_strobe_n(strbN), .busStrobeOe(strbOe),
    .readWriteDir(rw), .readWriteOe(rwOe), .busAddr(addr), .busAddrOe(addrOe),
    .busDataOut(dataOut), .busDataOe(dataOe));
  pbr_bus_master u_pbr_bus_master (.clk_sys(clk_sys), .wantBus(wantBus), .busAddr(addr),
    .busAddrOe(addrOe), .readWriteDir(rw), .bus_strobe_n(strbN), .bus_request_n(reqN),
    .busDataIn(dataIn));
  // one comparison, counted
  task check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys)
  begin
    cycleCount++;
    if (cycleCount == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  // write strobes seen on the pins, so posted and stalled writes can be judged
  logic strbPrevN = 1'b1;
  int wrCount = 0;
  logic [ADDR_W-1:0] wrAddr [2];
  logic [DATA_W-1:0] wrData [2];
  always @(posedge clk_sys)
  begin
    strbPrevN <= strbN;
    if (strbPrevN && !strbN && !rw && dataOe && wrCount < 2)
    begin
      wrAddr[wrCount] <= addr;
      wrData[wrCount] <= dataOut;
      wrCount <= wrCount + 1;
    end
  end
  // bounded wait for the acknowledge level
  task waitAck(input logic lvl);
    int n;
    n = 0;
    while (ackN !== lvl && n < 60)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task issue(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    coreReq <= 1'b1;
    coreWrite <= w;
    coreAddr <= a;
    coreWdata <= d;
  endtask
  // hold the request until stall is seen low, then drop it on the edge after the taking edge
  task awaitTaken(output int n);
    n = 0;
    @(posedge clk_sys);
    #1;
    while (stall !== 1'b0 && n < 200)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    coreReq <= 1'b0;
  endtask
  task t_reset;
    check("ack", ackN, 1'b1);
    check("strobe", strbN, 1'b1);
    check("enables", {strbOe, rwOe, addrOe, dataOe}, 4'hE);
    check("stall", stall, 1'b0);
    check("phase", phase, 1'b0);
    $display("end of reset test");
  endtask
  task t_read;
    int n;
    issue(1'b0, 24'h001234, '0);
    awaitTaken(n);
    repeat (8) @(posedge clk_sys);
    check("read data", rdata, {8'hA5, 24'h001234});
    $display("end of read test");
  endtask
  task t_release;
    int n;
    wantBus <= 1'b1;
    waitAck(1'b0);
    check("ack low", ackN, 1'b0);
    check("strobe float", strbOe, 1'b0);
    check("pins float", {rwOe, addrOe, dataOe}, 3'h0);
    check("phase at grant", phase, 1'b0);
    issue(1'b1, 24'h000010, 32'h0000BEEF);
    awaitTaken(n);
    check("posted write", n < 4, 1'b1);
    issue(1'b1, 24'h000020, 32'h0000CAFE);
    repeat (20) @(posedge clk_sys);
    check("second write stalls", stall, 1'b1);
    wantBus <= 1'b0;
    waitAck(1'b1);
    check("ack back", ackN, 1'b1);
    check("drivers back", {strbOe, rwOe, addrOe}, 3'h7);
    check("phase at return", phase, 1'b0);
    awaitTaken(n);
    check("stalled write done", n < 200, 1'b1);
    repeat (8) @(posedge clk_sys);
    check("write count", wrCount, 2);
    check("posted addr", wrAddr[0], 24'h000010);
    check("posted data", wrData[0], 32'h0000BEEF);
    check("stalled addr", wrAddr[1], 24'h000020);
    check("stalled data", wrData[1], 32'h0000CAFE);
    $display("end of release test");
  endtask
  task t_inhibit;
    inhibit <= 1'b1;
    wantBus <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check("blocked", ackN, 1'b1);
    inhibit <= 1'b0;
    waitAck(1'b0);
    check("granted", ackN, 1'b0);
    @(posedge clk_sys);
    inhibit <= 1'b1;
    waitAck(1'b1);
    check("reclaimed", {ackN, strbOe}, 2'h3);
    @(posedge clk_sys);
    wantBus <= 1'b0;
    // let the lifted request pass the synchroniser before the inhibit drops
    repeat (12) @(posedge clk_sys);
    inhibit <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check("no late grant", ackN, 1'b1);
    $display("end of inhibit test");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_read();
    t_release();
    t_inhibit();
    print_verdict();
  end
endmodule
